// *** sim/timer24_assertions.sv ***
// Port-level checks of the timer's APB slave and overflow flag.
// Assumes binding to timer24_selectable_clock, one pclk domain.
`timescale 1ns/100ps
`include "timer24_defines.svh"

module timer24_assertions (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   overflow_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Byte address of the control word
  localparam logic [`APB_ADDR_W-1:0] CTL_ADDR = `IDX_CONTROL_STATUS << 2;
  // Access that writes a zero to the flag
  wire logic clr_wr = psel && penable && pwrite && pready &&
                      paddr == CTL_ADDR && !pwdata[7];
  // Reads of the control word at their access edge
  wire logic ctl_rd = pready && !pwrite && paddr == CTL_ADDR;

  property p_ready_after_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no answer after setup");
  property p_ready_one_cycle;
    pready |=> !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle)
    else $error("answer held too long");
  property p_ready_idle;
    !psel |=> !pready;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("answer without request");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error outside an answer");
  property p_err_zero_data;
    pslverr && !pwrite |-> prdata == 32'h00000000;
  endproperty
  a_err_zero_data: assert property (p_err_zero_data)
    else $error("refused read returned data");
  property p_rd_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero)
    else $error("read data above the byte");
  property p_ctl_unused_zero;
    ctl_rd |-> prdata[2:1] == 2'b00 && !pslverr;
  endproperty
  a_ctl_unused_zero: assert property (p_ctl_unused_zero)
    else $error("unused control bits not zero");
  property p_flag_clear_by_write;
    $fell(overflow_flag) |-> $past(clr_wr) || $past(clr_wr, 2);
  endproperty
  a_flag_clear_by_write: assert property (p_flag_clear_by_write)
    else $error("flag fell without a clearing write");
endmodule : timer24_assertions

bind timer24_selectable_clock timer24_assertions u_timer24_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .overflow_flag);

// *** sim/timer24_selectable_clock_tb_top.sv ***
// Self-checking bench: registers, counting, reload and interrupt.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
`include "timer24_defines.svh"

module timer24_selectable_clock_tb_top;
  logic        pclk = 1'b0;        // 100 MHz register clock
  logic        presetn = 1'b0;     // Held low for 20 cycles
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        overflow_flag;
  logic [3:0]  src = 4'h0;         // Source clocks, slow against pclk
  int          sdiv [4];           // Half-period counters
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          diff;
  logic [31:0] rd;                 // Last read data
  logic        err;                // Last error response
  logic [31:0] seed = 32'h0000e706; // Fixed seed, repeatable run
  logic [23:0] c;
  logic [23:0] c2;
  logic [23:0] r;

  timer24_selectable_clock u_timer24_selectable_clock (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .clk_fast_internal(src[0]),
    .clk_external(src[1]), .clk_rtc(src[2]), .clk_slow_32k(src[3]),
    .irq, .overflow_flag);

  always #5 pclk = ~pclk;

  // Source k toggles every 4+k cycles: above the 3-cycle minimum
  always @(posedge pclk) begin
    for (int k = 0; k < 4; k++) begin
      sdiv[k] <= (sdiv[k] == 3 + k) ? 0 : sdiv[k] + 1;
      if (sdiv[k] == 3 + k) src[k] <= ~src[k];
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Ticks of source k seen in w cycles
  function automatic int exp_ticks(input int k, input int w);
    return w / (8 + 2 * k);
  endfunction : exp_ticks

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [17:0] idx,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= idx << 2;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-raises psel at once
    @(posedge pclk);
  endtask : apb

  // High byte first, since nothing is snapshotted
  task automatic rcount(output logic [23:0] v);
    apb(1'b0, `IDX_COUNT_HIGH, 8'h00);
    v[23:16] = rd[7:0];
    apb(1'b0, `IDX_COUNT_MIDDLE, 8'h00);
    v[15:8] = rd[7:0];
    apb(1'b0, `IDX_COUNT_LOW, 8'h00);
    v[7:0] = rd[7:0];
  endtask : rcount

  task automatic wcount(input logic [23:0] v);
    apb(1'b1, `IDX_COUNT_LOW, v[7:0]);
    apb(1'b1, `IDX_COUNT_MIDDLE, v[15:8]);
    apb(1'b1, `IDX_COUNT_HIGH, v[23:16]);
  endtask : wcount

  // Bounded wait for the rollover flag
  task automatic wait_flag;
    int n;
    n = 0;
    while (overflow_flag !== 1'b1 && n < 300) begin
      n++;
      @(posedge pclk);
    end
    check("overflow flag", 32'(overflow_flag), 32'h1);
  endtask : wait_flag

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, `IDX_CONTROL_STATUS + 18'(i), 8'h00);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 18'h0a070, 8'h00);
    check("unmapped error", 32'(err), 32'h1);
    // Random control values; run kept clear, flag not settable
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      apb(1'b1, `IDX_CONTROL_STATUS, seed[7:0] & 8'hf7);
      apb(1'b0, `IDX_CONTROL_STATUS, 8'h00);
      check("control", rd, 32'(seed[7:0] & 8'h71));
    end
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wcount(seed[23:0]);
      rcount(c);
      check("free-run load", 32'(c), 32'(seed[23:0]));
    end
    pstrb <= 4'h0;
    apb(1'b1, `IDX_COUNT_LOW, ~c[7:0]);
    pstrb <= 4'hf;
    rcount(c2);
    check("unstrobed write", 32'(c2), 32'(c));
    // Each source at its own rate; stop holds the count
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `IDX_CONTROL_STATUS, 8'h00);
      wcount(24'h000000);
      apb(1'b1, `IDX_CONTROL_STATUS, {1'b0, 2'(k), 5'h08});
      repeat (400) @(posedge pclk);
      apb(1'b1, `IDX_CONTROL_STATUS, {1'b0, 2'(k), 5'h00});
      rcount(c);
      repeat (50) @(posedge pclk);
      rcount(c2);
      check("held count", 32'(c2), 32'(c));
      diff = int'(c) - exp_ticks(k, 403);
      check("tick rate", 32'(diff >= -2 && diff <= 2), 32'h1);
    end
    // Reload mode: writes reach the reload value only
    wcount(24'hfffffd);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h10);
    seed = xs(seed);
    r = seed[23:0] & 24'h7fffff;
    wcount(r);
    rcount(c);
    check("live count kept", 32'(c), 32'h00fffffd);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h19);
    wait_flag();
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h90);
    rcount(c);
    check("reloaded", 32'((c - r) <= 24'h000002), 32'h1);
    check("masked irq", 32'(irq), 32'h0);
    apb(1'b0, `IDX_IRQ_STATUS, 8'h00);
    check("irq status", rd, 32'h1);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h01);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h00);
    // Free-run rollover with the interrupt unmasked
    wcount(24'hfffffe);
    apb(1'b1, `IDX_IRQ_MASK, 8'h01);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h09);
    wait_flag();
    repeat (3) @(posedge pclk);
    check("irq raised", 32'(irq), 32'h1);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h80);
    repeat (3) @(posedge pclk);
    check("irq disabled", 32'(irq), 32'h0);
    check("flag sticky", 32'(overflow_flag), 32'h1);
    rcount(c);
    check("wrapped", 32'(c <= 24'h000002), 32'h1);
    apb(1'b1, `IDX_IRQ_STATUS, 8'h01);
    apb(1'b1, `IDX_CONTROL_STATUS, 8'h00);
    repeat (3) @(posedge pclk);
    check("flag cleared", 32'(overflow_flag), 32'h0);
    final_report();
  end
endmodule : timer24_selectable_clock_tb_top

// *** verilog/count24_core.sv ***
// The 24-bit counter with its hidden reload value.
// Assumes byte writes arrive as one-cycle strobes from the bus side.
`timescale 1ns/100ps
`include "timer24_defines.svh"

module count24_core (
  input  wire logic                pclk,        // Register clock
  input  wire logic                presetn,     // Async reset, active low
  input  wire logic                tick,        // Selected source edge
  input  wire logic                run_control, // Count enable
  input  wire logic                reload_mode, // 1 auto-reload, 0 free
  input  wire logic [2:0]          wr_byte,     // Byte write strobes
  input  wire logic [7:0]          wr_data,     // Byte write data
  output logic      [`COUNT_W-1:0] count24,     // Live count
  output logic                     overflow     // One-cycle rollover
);

  logic [`COUNT_W-1:0] reload_value;   // Hidden reload register
  logic [`COUNT_W-1:0] next_count;     // Count after this cycle
  logic [`COUNT_W-1:0] next_reload;    // Reload after this cycle
  logic                advance;        // Counting edge this cycle
  logic                rollover;       // Advance from all ones

  assign advance  = tick & run_control;
  assign rollover = advance & (count24 == `COUNT_MAX);

  // Count update; a software byte write beats a tick in the same cycle
  always_comb begin
    next_count  = count24;
    next_reload = reload_value;
    if (rollover) begin
      next_count = reload_mode ? reload_value : '0;
    end else if (advance) begin
      next_count = count24 + `COUNT_W'(1);
    end
    for (int b = 0; b < 3; b++) begin
      if (wr_byte[b] && reload_mode) begin
        next_reload[b*8 +: 8] = wr_data;
      end else if (wr_byte[b]) begin
        next_count[b*8 +: 8] = wr_data;
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count24      <= `RST_COUNT;
      reload_value <= `RST_COUNT;
      overflow     <= 1'b0;
    end else begin
      count24      <= next_count;
      reload_value <= next_reload;
      overflow     <= rollover;
    end
  end

endmodule : count24_core

// *** verilog/source_edge_sync.sv ***
// Brings the four count clock sources into the pclk domain and turns
// each rising edge into a one-cycle tick.
// Assumes every source is at most a third of the pclk rate.
`timescale 1ns/100ps
`include "timer24_defines.svh"

module source_edge_sync (
  input  wire logic       pclk,     // Register clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic [3:0] src_in,   // Raw source clocks
  output logic      [3:0] src_tick  // One pulse per rising edge
);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_src
      // Stage 0 is read only by stage 1; stages 1 and 2 feed the edge
      logic [`SYNC_STAGES-1:0] stage;

      // Shift chain; a constant under reset
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage <= '0;
        end else begin
          stage <= {stage[`SYNC_STAGES-2:0], src_in[g]};
        end
      end

      // Rising edge seen between the two settled stages
      assign src_tick[g] = stage[1] & ~stage[2];
    end
  endgenerate

endmodule : source_edge_sync

// *** verilog/timer24_defines.svh ***
// Register map, field positions, reset values and bus figures for the
// 24-bit selectable-clock timer.
// Assumes a 32-bit APB slave with one word per register.
`ifndef TIMER24_DEFINES_SVH
`define TIMER24_DEFINES_SVH

// Register indices; the byte address is four times the index
`define IDX_CONTROL_STATUS 18'h0a068
`define IDX_COUNT_LOW      18'h0a069
`define IDX_COUNT_MIDDLE   18'h0a06a
`define IDX_COUNT_HIGH     18'h0a06b
`define IDX_IRQ_STATUS     18'h0a06c
`define IDX_IRQ_MASK       18'h0a06d

// APB address width, wide enough for four times the top index
`define APB_ADDR_W 18

// Control and status field positions
`define BIT_OVERFLOW_FLAG  7
`define BIT_CLK_SEL_HI     6
`define BIT_CLK_SEL_LO     5
`define BIT_RELOAD_MODE    4
`define BIT_RUN_CONTROL    3
`define BIT_IRQ_ENABLE     0

// Reset values
`define RST_CONTROL  8'h00
`define RST_COUNT    24'h000000
`define RST_IRQ_MASK 1'h0

// Count width and the value that rolls over
`define COUNT_W   24
`define COUNT_MAX 24'hffffff

// Synchroniser depth for the count clock sources
`define SYNC_STAGES 3

`endif

// *** verilog/timer24_pkg.sv ***
// Types shared by the timer files.
// Assumes timer24_defines.svh for all numbers.
package timer24_pkg;

  // Count clock sources, in select-field order
  typedef enum logic [1:0] {
    src_fast_internal_oscillator,
    src_external_oscillator,
    src_real_time_clock,
    src_slow_32k_oscillator
  } clk_src_e;

  // One byte lane of the count
  typedef logic [7:0] byte_t;

endpackage : timer24_pkg

// *** verilog/timer24_selectable_clock.sv ***
// Top of the 24-bit timer: APB register slave, control and status,
// interrupt status and mask, and the count path.
// Assumes the four count sources are free-running level clocks slower
// than a third of pclk, and pclk itself keeps running in low power.
//
// Register map, one byte of meaning per 32-bit word; the byte address
// is four times the register index:
//   control and status  flag, source select, mode, run, enable
//   count low byte      bits 7:0 of the live count
//   count middle byte   bits 15:8 of the live count
//   count high byte     bits 23:16 of the live count
//   interrupt status    bit 0, sticky, write one to clear
//   interrupt mask      bit 0, one lets the status through
// Only byte lane 0 of a write is used. An unmapped address is
// answered at once with pslverr and zero read data, and a write to it
// changes nothing. Every transfer is answered without wait states.
// Control and status fields: bit 7 overflow flag (write zero to clear,
// one has no effect), bits 6:5 source select, bit 4 reload mode,
// bit 3 run, bits 2:1 read zero, bit 0 overflow interrupt enable.
// Source select: 0 fast internal, 1 external, 2 real-time clock,
// 3 slow 32 kHz.
`timescale 1ns/100ps
`include "timer24_defines.svh"

module timer24_selectable_clock (
  input  wire logic                   pclk,      // APB clock, 100 MHz
  input  wire logic                   presetn,   // Async reset, active low
  input  wire logic                   psel,      // Slave select
  input  wire logic                   penable,   // Access phase
  input  wire logic                   pwrite,    // 1 write, 0 read
  input  wire logic [`APB_ADDR_W-1:0] paddr,     // Byte address
  input  wire logic [31:0]            pwdata,    // Write data
  input  wire logic [3:0]             pstrb,     // Byte lane strobes
  output logic      [31:0]            prdata,    // Read data
  output logic                        pready,    // Transfer done
  output logic                        pslverr,   // Unmapped address
  input  wire logic                   clk_fast_internal, // Source 0
  input  wire logic                   clk_external,      // Source 1
  input  wire logic                   clk_rtc,           // Source 2
  input  wire logic                   clk_slow_32k,      // Source 3
  output logic                        irq,       // Level interrupt
  output logic                        overflow_flag      // Mirror of flag
);

  // Matches a byte address against a register index
  function automatic logic reg_hit(
    input logic [`APB_ADDR_W-1:0] addr,
    input logic [`APB_ADDR_W-1:0] idx
  );
    reg_hit = (addr == {idx[`APB_ADDR_W-3:0], 2'b00});
  endfunction : reg_hit

  // Picks one byte of the live count for the read mux; the three
  // count registers differ only in the lane they show
  function automatic timer24_pkg::byte_t count_byte(
    input logic [`COUNT_W-1:0] count,
    input logic [1:0]          lane
  );
    count_byte = count[lane*8 +: 8];
  endfunction : count_byte

  // Control fields held by software
  timer24_pkg::clk_src_e count_clock_select;   // Source select
  logic                  reload_mode_select;   // 1 auto-reload
  logic                  run_control;          // Counting enabled
  logic                  overflow_irq_enable;  // Interrupt gate
  logic                  flag;                 // Sticky overflow flag

  // Interrupt status and mask words
  logic                  irq_status;           // Sticky, write one clear
  logic                  irq_mask;             // 1 lets status through

  // Count path
  logic [3:0]            src_tick;             // Edges of each source
  logic                  tick;                 // Edge of chosen source
  logic [`COUNT_W-1:0]   count24;              // Live count
  logic                  ovf_event;            // Rollover pulse
  logic [2:0]            wr_byte;              // Count byte strobes

  // Bus decode; all address bits are compared, so no register has an
  // alias and every other address is refused
  logic                  setup;                // Setup phase
  logic                  wr_fire;              // Write takes effect
  logic                  hit_ctl;              // Control and status
  logic                  hit_lo;               // Low count byte
  logic                  hit_mid;              // Middle count byte
  logic                  hit_hi;               // High count byte
  logic                  hit_ist;              // Interrupt status
  logic                  hit_imk;              // Interrupt mask
  logic                  hit_any;              // Any mapped register
  logic                  lane0;                // Low byte lane written
  logic [7:0]            wbyte;                // Low byte of write data
  logic [7:0]            ctl_read;             // Control word as read
  logic [31:0]           next_prdata;          // Read mux result
  logic                  ctl_wr;               // Control word written
  logic                  ist_wr;               // Status word written
  logic                  imk_wr;               // Mask word written
  logic                  rd_setup;             // Read seen in setup
  logic                  err_setup;            // Unmapped access setup

  // Next values of the software state
  logic                  next_flag;
  logic                  next_irq_status;
  logic                  next_irq;             // Gated interrupt level

  // Source edges into pclk; the count keeps going whenever pclk and the
  // chosen source run, independent of any processor clock gating
  source_edge_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_in   ({clk_slow_32k, clk_rtc, clk_external, clk_fast_internal}),
    .src_tick (src_tick)
  );

  // Selection acts on already synchronised ticks, so a change of
  // source can never make a runt edge
  assign tick = src_tick[count_clock_select];

  // Decode of the address, shared by read and write;
  // setup marks the one cycle in which the answer is decided
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite;
  assign hit_ctl = reg_hit(paddr, `IDX_CONTROL_STATUS);
  assign hit_lo  = reg_hit(paddr, `IDX_COUNT_LOW);
  assign hit_mid = reg_hit(paddr, `IDX_COUNT_MIDDLE);
  assign hit_hi  = reg_hit(paddr, `IDX_COUNT_HIGH);
  assign hit_ist = reg_hit(paddr, `IDX_IRQ_STATUS);
  assign hit_imk = reg_hit(paddr, `IDX_IRQ_MASK);
  assign hit_any = hit_ctl | hit_lo | hit_mid | hit_hi | hit_ist | hit_imk;
  assign lane0   = pstrb[0];
  assign wbyte   = pwdata[7:0];

  // Write strobes per register; a write with lane 0 off is answered
  // but changes nothing, so no field can be half written
  assign ctl_wr    = wr_fire & hit_ctl & lane0;
  assign ist_wr    = wr_fire & hit_ist & lane0;
  assign imk_wr    = wr_fire & hit_imk & lane0;

  // Read data and the error answer are decided in the setup cycle,
  // so both can stand in flip-flops by the access cycle
  assign rd_setup  = setup & ~pwrite;
  assign err_setup = setup & ~hit_any;

  // Byte strobes into the counter; the core sends them to the live
  // count or the reload value by mode
  assign wr_byte = {3{wr_fire & lane0}} & {hit_hi, hit_mid, hit_lo};

  // Counting runs at the pclk rate on synchronised ticks; a source
  // faster than a third of pclk would lose edges, which is the price
  // of keeping the whole block in one clock domain.
  // Counter with hidden reload value
  count24_core u_core (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (tick),
    .run_control (run_control),
    .reload_mode (reload_mode_select),
    .wr_byte     (wr_byte),
    .wr_data     (wbyte),
    .count24     (count24),
    .overflow    (ovf_event)
  );

  // Control word as software sees it; bits 2:1 read zero
  assign ctl_read = {flag,
                     count_clock_select,
                     reload_mode_select,
                     run_control,
                     2'b00,
                     overflow_irq_enable};

  // Read mux; count bytes are the live count, no snapshot is taken,
  // so a multi-byte read can tear if the count moves in between.
  // Reading the high byte first makes a carry show up as a low byte
  // that wrapped, which software can catch with a second pass
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctl) begin
      next_prdata = {24'h000000, ctl_read};
    end else if (hit_lo) begin
      next_prdata = {24'h000000, count_byte(count24, 2'h0)};
    end else if (hit_mid) begin
      next_prdata = {24'h000000, count_byte(count24, 2'h1)};
    end else if (hit_hi) begin
      next_prdata = {24'h000000, count_byte(count24, 2'h2)};
    end else if (hit_ist) begin
      next_prdata = {31'h0000_0000, irq_status};
    end else if (hit_imk) begin
      next_prdata = {31'h0000_0000, irq_mask};
    end
  end

  // Flag: writing zero clears it, writing one leaves it, and a
  // rollover in the same cycle wins over the clear. Writing one must
  // leave it, or a read-modify-write of the other fields would lose
  // an overflow that came in between
  always_comb begin
    next_flag = flag;
    if (ctl_wr && !wbyte[`BIT_OVERFLOW_FLAG]) begin
      next_flag = 1'b0;
    end
    if (ovf_event) begin
      next_flag = 1'b1;
    end
  end

  // Interrupt status: write one to clear, set wins over clear, so a
  // late clear can never hide a fresh overflow; the handler sees the
  // line stay up and comes back
  always_comb begin
    next_irq_status = irq_status;
    if (ist_wr && wbyte[0]) begin
      next_irq_status = 1'b0;
    end
    if (ovf_event) begin
      next_irq_status = 1'b1;
    end
  end

  // Control fields; only the low byte lane carries them. A new source
  // counts from its next synchronised edge; ticks are one-cycle
  // pulses, so a change of source can never count one edge twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_clock_select  <= timer24_pkg::clk_src_e'(
                             `RST_CONTROL >> `BIT_CLK_SEL_LO);
      reload_mode_select  <= 1'b0;
      run_control         <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (ctl_wr) begin
      count_clock_select  <= timer24_pkg::clk_src_e'(
        wbyte[`BIT_CLK_SEL_HI:`BIT_CLK_SEL_LO]);
      reload_mode_select  <= wbyte[`BIT_RELOAD_MODE];
      run_control         <= wbyte[`BIT_RUN_CONTROL];
      overflow_irq_enable <= wbyte[`BIT_IRQ_ENABLE];
    end
  end

  // Sticky bits; flag and status are set by the same rollover but
  // cleared by different writes, so each keeps its own next value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag       <= 1'b0;
      irq_status <= 1'b0;
    end else begin
      flag       <= next_flag;
      irq_status <= next_irq_status;
    end
  end

  // Interrupt mask; it survives a clear of the status, so software
  // sets it once and only clears status afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= `RST_IRQ_MASK;
    end else if (imk_wr) begin
      irq_mask <= wbyte[0];
    end
  end

  // Gated request, built from the next status so the line rises at
  // the same edge as the status bit and falls with its clear
  assign next_irq = next_irq_status & irq_mask & overflow_irq_enable;

  // Interrupt output; the enable bit gates the request ahead of the
  // mask so a disabled timer never raises the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq           <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      irq           <= next_irq;
      overflow_flag <= next_flag;
    end
  end

  // APB answer: data is captured in the setup cycle and pready rises
  // for the first access cycle, so every transfer has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= err_setup;
      // prdata holds the last read; writes and idle cycles leave it
      if (rd_setup) begin
        prdata <= next_prdata;
      end
    end
  end

endmodule : timer24_selectable_clock
